// File: rtl/cpu_power_state_control.sv
// processor power-state controller with apb control registers
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module cpu_power_state_control #(
	parameter int N_UNITS   = cpu_pwr_pkg::NUM_UNITS,
	parameter int STOP_CYCS = cpu_pwr_pkg::BUS_CLK_STOP_CYCLES
) (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [cpu_pwr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [cpu_pwr_pkg::DATA_W-1:0] pwdata,
	output logic      [cpu_pwr_pkg::DATA_W-1:0] prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire logic                           stop_clock_request_n,
	input  wire logic                           sleep_request_n,
	input  wire logic                           deep_sleep_request_n,
	input  wire logic                           core_supply_good,
	input  wire logic                           halt_exec,
	input  wire logic                           wake_event,
	input  wire logic                           bus_clk_level,
	input  wire logic                           core_voltage_lowered,
	input  wire logic                           die_overtemp,
	input  wire logic                           snoop_req,
	input  wire logic [N_UNITS-1:0]             unit_idle,
	output logic      [N_UNITS-1:0]             unit_power_en,
	output logic                                core_clk_en,
	output logic                                pll_only_run,
	output logic                                stop_grant_ack,
	output logic                                snoop_ack,
	output logic                                cache_invalidate,
	output logic                                exec_stop,
	output logic                                perf_low,
	output logic                                low_power_state_ind_n,
	output logic                                overtemp_shutdown_n,
	output logic      [cpu_pwr_pkg::VID_W-1:0]  core_voltage_code,
	output logic                                irq
);
	import cpu_pwr_pkg::*;

	typedef struct packed {
		pwr_state_e         state;
		logic               stop_grant;
		logic               trip;
		logic               inv_done;
		logic               inv_pulse;
		logic               snoop_ack;
		logic               psi_n;
		logic [VID_W-1:0]   vid_norm;
		logic [VID_W-1:0]   vid_low;
		logic [VID_W-1:0]   vid_out;
		logic [EV_W-1:0]    status;
		logic [EV_W-1:0]    mask;
		logic [N_UNITS-1:0] unit_pwr;
		logic [DATA_W-1:0]  rdata;
	} ctl_s;

	ctl_s r_ff;
	ctl_s nxt_r;
	logic clk_stopped;

	bus_clk_stop_detect #(
		.STOP_CYCLES (STOP_CYCS)
	) u_stop_det (
		.pclk          (pclk),
		.presetn       (presetn),
		.bus_clk_level (bus_clk_level),
		.clk_stopped   (clk_stopped)
	);

	function automatic logic [EV_W-1:0] ev_bit(input int idx);
		logic [EV_W-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFF_VID_NORM) || (a == OFF_VID_LOW) ||
			(a == OFF_STATE) || (a == OFF_INT_STAT) ||
			(a == OFF_INT_MASK);
	endfunction

	logic            wr_acc;
	logic            rd_setup;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] w1c;

	assign wr_acc   = psel & penable & pwrite & addr_mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;

	always_comb begin
		nxt_r = r_ff;
		ev = '0;
		w1c = '0;
		nxt_r.inv_pulse = 1'b0;
		nxt_r.snoop_ack = 1'b0;

		// one invalidate pulse after each reset, dirty lines dropped;
		// held off while supply is bad so it cannot repeat each cycle
		if (!r_ff.inv_done && core_supply_good) begin
			nxt_r.inv_pulse = 1'b1;
			nxt_r.inv_done = 1'b1;
		end

		// a glitch-free supply-good is relied on; low restarts core
		if (!core_supply_good) begin
			nxt_r.state = normal_st;
			nxt_r.stop_grant = 1'b0;
			nxt_r.inv_done = 1'b0;
		end else begin
			case (r_ff.state)
			normal_st: begin
				if (!stop_clock_request_n) begin
					nxt_r.state = light_idle_st;
					nxt_r.stop_grant = 1'b1;
					ev = ev_bit(EV_LIGHT_IDLE);
				end else if (halt_exec) begin
					nxt_r.state = light_idle_st;
					nxt_r.stop_grant = 1'b0;
					ev = ev_bit(EV_LIGHT_IDLE);
				end
			end
			light_idle_st: begin
				if (r_ff.stop_grant) begin
					if (!deep_sleep_request_n && clk_stopped) begin
						nxt_r.state = deep_sleep_st;
						ev = ev_bit(EV_DEEP);
					end else if (!sleep_request_n) begin
						nxt_r.state = sleep_st;
						ev = ev_bit(EV_SLEEP);
					end else if (stop_clock_request_n) begin
						nxt_r.state = normal_st;
						nxt_r.stop_grant = 1'b0;
						ev = ev_bit(EV_WAKE);
					end
				end else if (!stop_clock_request_n) begin
					// halted core picks up a stop-clock request
					nxt_r.stop_grant = 1'b1;
				end else if (wake_event) begin
					nxt_r.state = normal_st;
					ev = ev_bit(EV_WAKE);
				end
			end
			sleep_st: begin
				if (clk_stopped) begin
					nxt_r.state = deep_sleep_st;
					ev = ev_bit(EV_DEEP);
				end else if (sleep_request_n) begin
					nxt_r.state = light_idle_st;
				end
			end
			deep_sleep_st: begin
				if (core_voltage_lowered) begin
					nxt_r.state = deeper_sleep_st;
					ev = ev_bit(EV_DEEPER);
				end else if (!clk_stopped) begin
					nxt_r.state = sleep_st;
				end
			end
			deeper_sleep_st: begin
				if (!core_voltage_lowered) begin
					nxt_r.state = deep_sleep_st;
				end
			end
			default: begin
				nxt_r.state = normal_st;
				nxt_r.stop_grant = 1'b0;
			end
			endcase
		end

		// trip is sticky until reset: the platform is expected to
		// cut power, so no software path releases it
		if (die_overtemp && !r_ff.trip) begin
			nxt_r.trip = 1'b1;
			ev = ev | ev_bit(EV_TRIP);
		end

		// snoops served only in normal and light idle; dropped in sleep, deep and deeper sleep
		if (snoop_req) begin
			if (r_ff.state == normal_st || r_ff.state == light_idle_st) begin
				nxt_r.snoop_ack = 1'b1;
			end else begin
				ev = ev | ev_bit(EV_SNOOP_DROP);
			end
		end

		nxt_r.psi_n = !(nxt_r.state == deep_sleep_st ||
			nxt_r.state == deeper_sleep_st);
		nxt_r.vid_out = nxt_r.trip ? r_ff.vid_low : r_ff.vid_norm;

		// idle units lose power in normal with no trip; everything off otherwise
		if (r_ff.state == normal_st && !r_ff.trip) begin
			nxt_r.unit_pwr = ~unit_idle;
		end else begin
			nxt_r.unit_pwr = '0;
		end

		if (wr_acc) begin
			case (paddr)
			OFF_VID_NORM: nxt_r.vid_norm = pwdata[VID_W-1:0];
			OFF_VID_LOW:  nxt_r.vid_low = pwdata[VID_W-1:0];
			OFF_INT_STAT: w1c = pwdata[EV_W-1:0];
			OFF_INT_MASK: nxt_r.mask = pwdata[EV_W-1:0];
			default: begin
			end
			endcase
		end
		// a new event in the clear cycle survives the clear
		nxt_r.status = (r_ff.status & ~w1c) | ev;

		if (rd_setup) begin
			nxt_r.rdata = '0;
			case (paddr)
			OFF_VID_NORM: nxt_r.rdata[VID_W-1:0] = r_ff.vid_norm;
			OFF_VID_LOW:  nxt_r.rdata[VID_W-1:0] = r_ff.vid_low;
			OFF_STATE: begin
				nxt_r.rdata[ST_STATE_LSB +: $bits(pwr_state_e)] = r_ff.state;
				nxt_r.rdata[ST_GRANT_BIT] = r_ff.stop_grant;
				nxt_r.rdata[ST_TRIP_BIT] = r_ff.trip;
				nxt_r.rdata[ST_PSI_BIT] = ~r_ff.psi_n;
			end
			OFF_INT_STAT: nxt_r.rdata[EV_W-1:0] = r_ff.status;
			OFF_INT_MASK: nxt_r.rdata[EV_W-1:0] = r_ff.mask;
			default:      nxt_r.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff.state <= normal_st;
			r_ff.stop_grant <= 1'b0;
			r_ff.trip <= 1'b0;
			r_ff.inv_done <= 1'b0;
			r_ff.inv_pulse <= 1'b0;
			r_ff.snoop_ack <= 1'b0;
			r_ff.psi_n <= 1'b1;
			r_ff.vid_norm <= VID_NORM_RST;
			r_ff.vid_low <= VID_LOW_RST;
			r_ff.vid_out <= VID_NORM_RST;
			r_ff.status <= '0;
			r_ff.mask <= INT_MASK_RST;
			r_ff.unit_pwr <= '0;
			r_ff.rdata <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// zero-wait slave: read data was caught in the setup cycle
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_mapped(paddr);
	assign prdata  = r_ff.rdata;

	assign unit_power_en         = r_ff.unit_pwr;
	assign core_clk_en           = (r_ff.state == normal_st) & ~r_ff.trip;
	assign pll_only_run          = (r_ff.state == sleep_st);
	assign stop_grant_ack        = r_ff.stop_grant;
	assign snoop_ack             = r_ff.snoop_ack;
	assign cache_invalidate      = r_ff.inv_pulse;
	assign exec_stop             = r_ff.trip | (r_ff.state != normal_st);
	assign perf_low              = r_ff.trip;
	assign overtemp_shutdown_n   = ~r_ff.trip;
	assign low_power_state_ind_n = r_ff.psi_n;
	assign core_voltage_code     = r_ff.vid_out;
	assign irq                   = |(r_ff.status & r_ff.mask);

endmodule

// File: rtl/cpu_pwr_pkg.sv
// constants and types shared by the power-state controller
// Functional notes
// - exactly five power states exist
// - normal state powers down idle units
// - stop-clock request enters stop-grant
// - stop-clock or halt enters light idle
// - light idle still services snoops
// - sleep request in stop-grant enters sleep
// - bus clock stop in sleep: deep sleep
// - deep sleep entry asserts state indication
// - voltage lowered in deep: deeper sleep
// - deep and deeper sleep ignore snoops
// - reset invalidates cache, no write-back
// - overtemp: trip output, lowest perf, halt
// - six-bit voltage code to regulator
// - deep request plus clock stop: deep
package cpu_pwr_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int VID_W  = 6;
	localparam int EV_W   = 7;

	localparam logic [ADDR_W-1:0] OFF_VID_NORM = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_VID_LOW  = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STATE    = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_INT_MASK = 8'h10;

	localparam logic [VID_W-1:0] VID_NORM_RST = 6'h10;
	localparam logic [VID_W-1:0] VID_LOW_RST  = 6'h20;
	localparam logic [EV_W-1:0]  INT_MASK_RST = 7'h00;

	// interrupt status / mask bit positions
	localparam int EV_LIGHT_IDLE = 0;
	localparam int EV_SLEEP      = 1;
	localparam int EV_DEEP       = 2;
	localparam int EV_DEEPER     = 3;
	localparam int EV_WAKE       = 4;
	localparam int EV_TRIP       = 5;
	localparam int EV_SNOOP_DROP = 6;

	// state register read layout
	localparam int ST_STATE_LSB = 0;
	localparam int ST_GRANT_BIT = 5;
	localparam int ST_TRIP_BIT  = 6;
	localparam int ST_PSI_BIT   = 7;

	localparam int BUS_CLK_STOP_CYCLES = 8;
	localparam int NUM_UNITS           = 4;

	typedef enum logic [4:0] {
		normal_st       = 5'h01,
		light_idle_st   = 5'h02,
		sleep_st        = 5'h04,
		deep_sleep_st   = 5'h08,
		deeper_sleep_st = 5'h10
	} pwr_state_e;

endpackage

// File: rtl/bus_clk_stop_detect.sv
// detects that the sampled bus clock has stopped toggling
`timescale 1ns/100ps
module bus_clk_stop_detect #(
	parameter int STOP_CYCLES = cpu_pwr_pkg::BUS_CLK_STOP_CYCLES
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic bus_clk_level,
	output logic      clk_stopped
);
	import cpu_pwr_pkg::*;

	localparam int CNT_W = $clog2(STOP_CYCLES + 1);
	localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(STOP_CYCLES);

	typedef struct packed {
		logic             prev;
		logic [CNT_W-1:0] cnt;
		logic             stopped;
	} det_s;

	det_s r_ff;
	det_s nxt_r;

	// a level held for the full window counts as stopped; a
	// single edge restarts the count, so restart is seen at once
	always_comb begin
		nxt_r = r_ff;
		nxt_r.prev = bus_clk_level;
		if (bus_clk_level != r_ff.prev) begin
			nxt_r.cnt = '0;
			nxt_r.stopped = 1'b0;
		end else if (r_ff.cnt != CNT_MAX) begin
			nxt_r.cnt = r_ff.cnt + CNT_W'(1);
		end else begin
			nxt_r.stopped = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff <= '0;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign clk_stopped = r_ff.stopped;

endmodule

// File: tb/cpu_pwr_assertions.sv
// port checks for the power-state controller
`timescale 1ns/100ps
module cpu_pwr_assertions #(
	parameter int N_UNITS = 4
) (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               stop_clock_request_n,
	input wire logic               core_supply_good,
	input wire logic               bus_clk_level,
	input wire logic               die_overtemp,
	input wire logic               snoop_req,
	input wire logic [N_UNITS-1:0] unit_idle,
	input wire logic [N_UNITS-1:0] unit_power_en,
	input wire logic               core_clk_en,
	input wire logic               pll_only_run,
	input wire logic               stop_grant_ack,
	input wire logic               snoop_ack,
	input wire logic               cache_invalidate,
	input wire logic               perf_low,
	input wire logic               low_power_state_ind_n,
	input wire logic               overtemp_shutdown_n
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_awake;
		low_power_state_ind_n && !pll_only_run;
	endsequence
	sequence s_deep_exit;
		$rose(low_power_state_ind_n);
	endsequence
	a_units_follow_idle: assert property (core_clk_en |=>
		unit_power_en == ~$past(unit_idle)) else $error("unit gating");
	a_stop_grant_entry: assert property (!stop_clock_request_n &&
		core_clk_en && core_supply_good && !die_overtemp |=>
		stop_grant_ack && !core_clk_en) else $error("no stop grant");
	a_snoop_served: assert property (snoop_req ##0 s_awake |=>
		snoop_ack) else $error("snoop not acked");
	a_snoop_ignored: assert property (snoop_req &&
		!low_power_state_ind_n |=> !snoop_ack) else $error("deep snoop");
	a_deep_entry: assert property ($fell(low_power_state_ind_n) |->
		$past(!core_clk_en) && $stable(bus_clk_level))
		else $error("deep entry");
	a_deep_exit: assert property (s_deep_exit |-> pll_only_run)
		else $error("deep exit");
	a_trip_cause: assert property ($fell(overtemp_shutdown_n) |->
		$past(die_overtemp)) else $error("trip without heat");
	a_trip_hold: assert property (!overtemp_shutdown_n |=>
		!overtemp_shutdown_n && perf_low) else $error("trip lost");
	a_inval_pulse: assert property (cache_invalidate |=>
		!cache_invalidate) else $error("invalidate too long");
endmodule

bind cpu_power_state_control cpu_pwr_assertions #(.N_UNITS(N_UNITS)) u_chk (.*);

// File: tb/chipset_vr_model.sv
// chipset and regulator stand-in on the power pins
`timescale 1ns/100ps
module chipset_vr_model (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic clk_run,
	input  wire logic lower_v,
	input  wire logic low_power_state_ind_n,
	output logic      bus_clk_level,
	output logic      core_voltage_lowered,
	output logic      core_supply_good
);
	logic       bclk_ff;
	logic       vlow_ff;
	logic [2:0] pg_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_ff   <= 1'b0;
			vlow_ff   <= 1'b0;
			pg_cnt_ff <= 3'h0;
		end else begin
			if (clk_run)
				bclk_ff <= ~bclk_ff;
			// never lower before the deep indication
			vlow_ff <= lower_v && !low_power_state_ind_n;
			// settle delay; never drops, so glitch free
			if (pg_cnt_ff != 3'h7)
				pg_cnt_ff <= pg_cnt_ff + 3'h1;
		end
	end
	assign bus_clk_level        = bclk_ff;
	assign core_voltage_lowered = vlow_ff;
	assign core_supply_good     = (pg_cnt_ff == 3'h7);
endmodule

// File: tb/tb_top.sv
// self-checking bench for the power-state controller
`timescale 1ns/100ps
module tb_top;
	import cpu_pwr_pkg::*;
	logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
	logic              penable = 1'b0, pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0, prdata, rd_q, n_inv;
	logic              pready, pslverr, err_q, irq, exec_stop, perf_low;
	logic              stop_clock_request_n = 1'b1, sleep_request_n = 1'b1;
	logic              deep_sleep_request_n = 1'b1, halt_exec = 1'b0;
	logic              wake_event = 1'b0, die_overtemp = 1'b0;
	logic              snoop_req = 1'b0, clk_run = 1'b1, lower_v = 1'b0;
	logic              core_supply_good, bus_clk_level, core_voltage_lowered;
	logic [3:0]        unit_idle = 4'h0, unit_power_en;
	logic              core_clk_en, pll_only_run, stop_grant_ack, snoop_ack;
	logic              cache_invalidate, low_power_state_ind_n;
	logic              overtemp_shutdown_n;
	logic [5:0]        core_voltage_code;
	int                n_mismatch = 0, checks_done = 0, i;

	always #2 pclk = ~pclk;

	cpu_power_state_control u_cpu_power_state_control (.*);
	chipset_vr_model u_chipset_vr_model (.*);

	task automatic tally_and_finish;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		if (pready !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
		rd_q = prdata;
		err_q = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll the state register; a stuck state ends the run
	task automatic ws(input logic [4:0] e);
		int k;
		for (k = 0; k < 60; k++) begin
			apb(1'b0, OFF_STATE, 32'h0);
			if (rd_q[4:0] === e)
				break;
		end
		chk(rd_q & 32'h1f, {27'h0, e});
		if (rd_q[4:0] !== e)
			tally_and_finish();
	endtask
	// snoops only in settled states, never around sleep
	task automatic snoop(input logic exp);
		@(posedge pclk);
		snoop_req <= 1'b1;
		@(posedge pclk);
		snoop_req <= 1'b0;
		@(negedge pclk);
		chk({31'h0, snoop_ack}, {31'h0, exp});
		@(posedge pclk);
	endtask

	initial begin
		n_inv = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// pulse waits for the model's supply-good settle delay
		for (i = 0; i < 12; i++) begin
			@(negedge pclk);
			if (cache_invalidate === 1'b1)
				n_inv++;
		end
		chk(n_inv, 32'h1);
		chk({26'h0, core_voltage_code}, {26'h0, VID_NORM_RST});
		apb(1'b0, OFF_VID_LOW, 32'h0);
		chk(rd_q, {26'h0, VID_LOW_RST});
		apb(1'b0, 8'h14, 32'h0);
		chk({31'h0, err_q}, 32'h1);
		apb(1'b1, OFF_STATE, 32'hff);
		ws(normal_st);
		unit_idle <= 4'h5;
		repeat (3) @(posedge pclk);
		chk({28'h0, unit_power_en}, 32'ha);
		apb(1'b1, OFF_VID_NORM, 32'h15);
		repeat (2) @(posedge pclk);
		chk({26'h0, core_voltage_code}, 32'h15);
		apb(1'b1, OFF_INT_MASK, 32'h1 << EV_LIGHT_IDLE);
		snoop(1'b1);
		stop_clock_request_n <= 1'b0;
		ws(light_idle_st);
		chk({31'h0, core_clk_en}, 32'h0);
		chk({31'h0, stop_grant_ack & irq}, 32'h1);
		apb(1'b1, OFF_INT_STAT, 32'h1 << EV_LIGHT_IDLE);
		@(negedge pclk);
		chk({31'h0, irq}, 32'h0);
		snoop(1'b1);
		sleep_request_n <= 1'b0;
		deep_sleep_request_n <= 1'b0;
		ws(sleep_st);
		chk({31'h0, pll_only_run}, 32'h1);
		clk_run <= 1'b0;
		ws(deep_sleep_st);
		chk({31'h0, low_power_state_ind_n}, 32'h0);
		snoop(1'b0);
		apb(1'b0, OFF_INT_STAT, 32'h0);
		chk({31'h0, rd_q[EV_SNOOP_DROP] & ~irq}, 32'h1);
		lower_v <= 1'b1;
		ws(deeper_sleep_st);
		snoop(1'b0);
		lower_v <= 1'b0;
		ws(deep_sleep_st);
		clk_run <= 1'b1;
		ws(sleep_st);
		chk({31'h0, low_power_state_ind_n}, 32'h1);
		sleep_request_n <= 1'b1;
		ws(light_idle_st);
		stop_clock_request_n <= 1'b1;
		ws(normal_st);
		stop_clock_request_n <= 1'b0;
		ws(light_idle_st);
		clk_run <= 1'b0;
		ws(deep_sleep_st);
		clk_run <= 1'b1;
		deep_sleep_request_n <= 1'b1;
		stop_clock_request_n <= 1'b1;
		ws(normal_st);
		halt_exec <= 1'b1;
		@(posedge pclk);
		halt_exec <= 1'b0;
		ws(light_idle_st);
		chk({31'h0, stop_grant_ack}, 32'h0);
		stop_clock_request_n <= 1'b0;
		ws(light_idle_st);
		chk({31'h0, stop_grant_ack}, 32'h1);
		stop_clock_request_n <= 1'b1;
		ws(normal_st);
		halt_exec <= 1'b1;
		@(posedge pclk);
		halt_exec <= 1'b0;
		ws(light_idle_st);
		wake_event <= 1'b1;
		ws(normal_st);
		wake_event <= 1'b0;
		apb(1'b1, OFF_VID_LOW, 32'h2a);
		die_overtemp <= 1'b1;
		repeat (4) @(posedge pclk);
		die_overtemp <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({31'h0, overtemp_shutdown_n}, 32'h0);
		chk({30'h0, perf_low, exec_stop}, 32'h3);
		chk({26'h0, core_voltage_code}, 32'h2a);
		apb(1'b0, OFF_INT_STAT, 32'h0);
		chk(rd_q & (32'h1 << EV_TRIP), 32'h1 << EV_TRIP);
		tally_and_finish();
	end
endmodule
